// ### sfcr_cfg_if.sv
`timescale 1ns/1ps
interface sfcr_cfg_if;
    logic [7:0] cfg;
    logic [7:0] stat;
    logic       wr_tgl;
    logic [7:0] wr_stat;
    logic [7:0] wr_cfg;
    logic       wr_two;
    logic       clr_tgl;
    logic       soft_tgl;
    logic       wren_tgl;
    logic       wrdi_tgl;
    modport core (output cfg, output stat, input wr_tgl, input wr_stat, input wr_cfg,
                  input wr_two, input clr_tgl, input soft_tgl, input wren_tgl,
                  input wrdi_tgl);
    modport link (input cfg, input stat, output wr_tgl, output wr_stat, output wr_cfg,
                  output wr_two, output clr_tgl, output soft_tgl, output wren_tgl,
                  output wrdi_tgl);
endinterface

// ### sfcr_core.sv
`timescale 1ns/1ps
// Operation
// R1: read 35h, write 01h sixteen-cycle transfer
// R2: latency code bits set mode/dummy cycles
// R3: fast/dual/quad-out: 8 dummy, none for 11
// R4: dual-io and quad-io mode/dummy table
// R5: host uses plain read up to 50MHz
// R6: host uses code 10 up to 108MHz
// R7: higher-band code stays valid at lower rates
// R8: mode bits allow instruction-less repeat reads
// R9: protect bit sets range start top/bottom
// R10: clearing programmed otp bit sets program error
// R11: volatile select makes protect bits reset 111
// R12: parameter bit places small sectors top/bottom
// R13: uniform sectors make parameter bit inert
// R14: protect start and parameter location independent
// R15: quad bit turns wp/hold into data
// R16: host sets quad before quad commands
// R17: single/dual reads work with quad set
// R18: freeze locks protect, otp bits, otp space
// R19: unfrozen bits remain writable
// R20: freeze cleared only by power/hw reset
// R21: one write may set freeze and others
// R22: host programs otp bits before array use
// R23: write disabled when swd set, wp low
// R24: program error keeps busy until clear-status (soft reset also clears it)
// R25: locked bits kept, unlocked bits still update
module sfcr_core
    import sfcr_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       sck_in,
    input  wire logic       cs_n_in,
    input  wire logic [3:0] io_in,
    input  wire logic       uniform_sectors_in,
    output logic      [3:0] io_out,
    output logic      [3:0] io_oe_out,
    output logic      [7:0] config_reg_one_out,
    output logic      [7:0] status_reg_one_out,
    output logic            protect_from_bottom_out,
    output logic            params_at_top_out,
    output logic            otp_locked_out,
    output logic            wp_active_n_out,
    output logic            hold_active_n_out
);
    import sfcr_pkg::*;
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] stat;
        logic [2:0] wr_s;
        logic [2:0] clr_s;
        logic [2:0] soft_s;
        logic [2:0] wren_s;
        logic [2:0] wrdi_s;
        logic [3:0] io_s1;
        logic [3:0] io_s2;
        logic       tb;
        logic       parm;
        logic       lock;
        logic       wp_n;
        logic       hold_n;
    } sfcr_core_t;
    sfcr_core_t r, n;
    sfcr_cfg_if cfg_if ();
    logic [7:0] wcfg, nv;
    logic       err;

    sfcr_link u_link (
        .reset_n_in(reset_n_in),
        .sck_in    (sck_in),
        .cs_n_in   (cs_n_in),
        .io_in     (io_in),
        .io_out    (io_out),
        .io_oe_out (io_oe_out),
        .cfg_if    (cfg_if.link)
    );
    assign cfg_if.cfg  = r.cfg;
    assign cfg_if.stat = r.stat;

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        wcfg = cfg_if.wr_two ? cfg_if.wr_cfg : r.cfg;
        nv = r.cfg;
        err = 1'b0;
        n.wr_s   = {r.wr_s[1:0], cfg_if.wr_tgl};
        n.clr_s  = {r.clr_s[1:0], cfg_if.clr_tgl};
        n.soft_s = {r.soft_s[1:0], cfg_if.soft_tgl};
        n.io_s1  = io_in;
        n.io_s2  = r.io_s1;
        n.wren_s = {r.wren_s[1:0], cfg_if.wren_tgl};
        n.wrdi_s = {r.wrdi_s[1:0], cfg_if.wrdi_tgl};
        if (r.clr_s[2] != r.clr_s[1]) begin
            n.stat[PERR_POS] = 1'b0;
            n.stat[BUSY_POS] = 1'b0; // R24
        end
        if (r.soft_s[2] != r.soft_s[1]) begin
            n.stat[WEL_POS] = 1'b0;
            n.stat[PERR_POS] = 1'b0;
            n.stat[BUSY_POS] = 1'b0;
            if (r.cfg[PROTECT_VOLATILITY_SELECT_POS]) n.stat[BP_LSB+2:BP_LSB] = BP_VOLATILE_RESET; // R11
        end
        if (r.wren_s[2] != r.wren_s[1] && !r.stat[BUSY_POS]) n.stat[WEL_POS] = 1'b1;
        if (r.wrdi_s[2] != r.wrdi_s[1]) n.stat[WEL_POS] = 1'b0;
        if (r.wr_s[2] != r.wr_s[1] && !r.stat[BUSY_POS] && r.stat[WEL_POS] &&
            !(r.stat[SWD_POS] && !r.io_s2[2])) begin // R23
            nv[LAT_HI_POS:LAT_LO_POS] = wcfg[LAT_HI_POS:LAT_LO_POS];
            nv[QUAD_POS]   = wcfg[QUAD_POS];
            nv[FREEZE_POS] = r.cfg[FREEZE_POS] | wcfg[FREEZE_POS]; // R19 R21
            nv[RSVD_POS]   = 1'b0;
            if (!r.cfg[FREEZE_POS]) begin // R18 R25
                nv[TOP_BOTTOM_PROTECT_POS] = r.cfg[TOP_BOTTOM_PROTECT_POS] | wcfg[TOP_BOTTOM_PROTECT_POS];
                nv[PROTECT_VOLATILITY_SELECT_POS]   = r.cfg[PROTECT_VOLATILITY_SELECT_POS] | wcfg[PROTECT_VOLATILITY_SELECT_POS];
                nv[PARM_POS]   = r.cfg[PARM_POS] | wcfg[PARM_POS];
                n.stat[BP_LSB+2:BP_LSB] = cfg_if.wr_stat[BP_LSB+2:BP_LSB];
            end
            err = |(r.cfg & OTP_MASK & ~wcfg) & cfg_if.wr_two; // R10
            n.stat[SWD_POS] = cfg_if.wr_stat[SWD_POS];
            n.cfg = nv;
            n.stat[PERR_POS] = err;
            n.stat[BUSY_POS] = err; // R24
            n.stat[WEL_POS]  = err;
        end
        n.tb     = n.cfg[TOP_BOTTOM_PROTECT_POS]; // R9 R14
        n.parm   = n.cfg[PARM_POS] & ~uniform_sectors_in; // R12 R13
        n.lock   = n.cfg[FREEZE_POS]; // R18
        n.wp_n   = n.cfg[QUAD_POS] | r.io_s2[2]; // R15 R17
        n.hold_n = n.cfg[QUAD_POS] | r.io_s2[3]; // R15
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r <= '0;
            r.cfg  <= CFG_RESET; // R20
            r.stat <= STAT_RESET;
            r.wp_n <= 1'b1;
            r.hold_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign config_reg_one_out      = r.cfg;
    assign status_reg_one_out      = r.stat;
    assign protect_from_bottom_out = r.tb;
    assign params_at_top_out       = r.parm;
    assign otp_locked_out          = r.lock;
    assign wp_active_n_out         = r.wp_n;
    assign hold_active_n_out       = r.hold_n;
endmodule

// ### sfcr_core_props.sv
`timescale 1ns/1ps
module sfcr_core_props
    import sfcr_pkg::*;
(
    input wire logic       sys_clk_in,
    input wire logic       reset_n_in,
    input wire logic       uniform_sectors_in,
    input wire logic [7:0] config_reg_one_out,
    input wire logic [7:0] status_reg_one_out,
    input wire logic       protect_from_bottom_out,
    input wire logic       params_at_top_out,
    input wire logic       otp_locked_out,
    input wire logic       wp_active_n_out,
    input wire logic       hold_active_n_out
);
    // ----
    // checks
    // ----
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [7:0] c;
    assign c = config_reg_one_out;
    a_perr_busy: assert property (status_reg_one_out[6] |-> status_reg_one_out[0])
        else $error("error flag without busy");
    a_prot_start: assert property ($stable(c) [*4] |-> protect_from_bottom_out == c[5])
        else $error("protect start wrong");
    a_parm_place: assert property ((!uniform_sectors_in && $stable(c)) [*4]
        |-> params_at_top_out == c[2]) else $error("parameter place wrong");
    a_parm_inert: assert property (uniform_sectors_in [*4] |-> !params_at_top_out)
        else $error("parameter bit active on uniform");
    a_lock_out: assert property ($stable(c) [*4] |-> otp_locked_out == c[0])
        else $error("lock output wrong");
    a_quad_pins: assert property (c[1] [*4] |-> wp_active_n_out && hold_active_n_out)
        else $error("pin functions active in quad");
    a_otp_keep: assert property (!(|($past(c) & OTP_MASK & ~c)))
        else $error("otp bit cleared");
    a_frozen_keep: assert property (c[0] |=> (c & 8'h24) == ($past(c) & 8'h24))
        else $error("frozen bit changed");
    a_freeze_hold: assert property (c[0] |=> c[0])
        else $error("freeze cleared");
    c_freeze: cover property ($rose(c[0]));
    c_perr: cover property ($rose(status_reg_one_out[6]));
    c_quad: cover property ($rose(c[1]));
endmodule
bind sfcr_core sfcr_core_props u_props (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .uniform_sectors_in(uniform_sectors_in), .config_reg_one_out(config_reg_one_out),
    .status_reg_one_out(status_reg_one_out), .protect_from_bottom_out(protect_from_bottom_out),
    .params_at_top_out(params_at_top_out), .otp_locked_out(otp_locked_out),
    .wp_active_n_out(wp_active_n_out), .hold_active_n_out(hold_active_n_out));

// ### sfcr_host.sv
`timescale 1ns/1ps
module sfcr_host (
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      si_out,
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    localparam realtime HALF = 62.5;
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b1;
    end
    // ----
    // one framed command, clock runs only while selected
    // ----
    task automatic frame(input logic [7:0] cmd, input logic [31:0] wdat, input int nw,
                         input int nr, input bit meas, output logic [7:0] rdat, output int lat);
        logic [39:0] sh;
        sh = {cmd, wdat};
        rdat = 8'h00;
        lat = 0;
        #17 cs_n_out <= 1'b0;
        for (int i = 0; i < 8 + nw; i++) begin
            si_out <= sh[39 - i];
            #HALF sck_out <= 1'b1;
            #HALF sck_out <= 1'b0;
        end
        si_out <= ~si_out;
        if (meas) begin
            #5;
            while (so_oe_in !== 1'b1 && lat < 12) begin
                #(HALF - 5) sck_out <= 1'b1;
                #HALF sck_out <= 1'b0;
                #5 lat++;
            end
        end
        for (int i = 0; i < nr; i++) begin
            #HALF sck_out <= 1'b1;
            rdat = {rdat[6:0], so_in};
            #HALF sck_out <= 1'b0;
        end
        #HALF cs_n_out <= 1'b1;
        #HALF;
    endtask
endmodule

// ### sfcr_link.sv
`timescale 1ns/1ps
module sfcr_link
    import sfcr_pkg::*;
(
    input  wire logic reset_n_in,
    input  wire logic sck_in,
    input  wire logic cs_n_in,
    input  wire logic [3:0] io_in,
    output logic      [3:0] io_out,
    output logic      [3:0] io_oe_out,
    sfcr_cfg_if.link  cfg_if
);
    import sfcr_pkg::*;
    // ------------------------------------------------------------
    // serial command engine on the link clock
    // ------------------------------------------------------------
    typedef struct packed {
        sfcr_state_t st;
        logic [7:0]  cmd;
        logic [7:0]  sh;
        logic [5:0]  cnt;
        logic        cont;
        logic        wr_tgl;
        logic [7:0]  wr_stat;
        logic [7:0]  wr_cfg;
        logic        wr_two;
        logic        clr_tgl;
        logic        soft_tgl;
        logic        wren_tgl;
        logic        wrdi_tgl;
    } sfcr_link_t;
    sfcr_link_t r, n;
    logic [7:0] cfg_s1, cfg_s2, stat_s1, stat_s2;
    logic [3:0] mode_cyc, dummy_cyc;
    logic [2:0] width;
    logic [3:0] in_bits;

    always_ff @(posedge sck_in) begin
        cfg_s1  <= cfg_if.cfg;
        cfg_s2  <= cfg_s1;
        stat_s1 <= cfg_if.stat;
        stat_s2 <= stat_s1;
    end

    // latency per command and code
    always_comb begin
        mode_cyc  = 4'h0;
        dummy_cyc = (cfg_s2[LAT_HI_POS:LAT_LO_POS] == LC_NO_WAIT) ? 4'h0 : DUMMY_EIGHT; // R3
        case (r.cmd)
            CMD_READ: dummy_cyc = 4'h0;
            CMD_DUAL_IO_READ: begin
                mode_cyc = MODE_DUAL_IO; // R4
                case (cfg_s2[LAT_HI_POS:LAT_LO_POS])
                    LC_MID:  dummy_cyc = 4'h1;
                    LC_HIGH: dummy_cyc = 4'h2;
                    default: dummy_cyc = 4'h0;
                endcase
            end
            CMD_QUAD_IO_READ: begin
                mode_cyc = MODE_QUAD_IO; // R4
                case (cfg_s2[LAT_HI_POS:LAT_LO_POS])
                    LC_NO_WAIT: dummy_cyc = 4'h1;
                    LC_HIGH:    dummy_cyc = 4'h5;
                    default:    dummy_cyc = 4'h4;
                endcase
            end
            default: ;
        endcase
        case (r.cmd)
            CMD_DUAL_OUT_READ, CMD_DUAL_IO_READ: width = 3'h2;
            CMD_QUAD_OUT_READ, CMD_QUAD_IO_READ: width = 3'h4;
            default: width = 3'h1;
        endcase
        in_bits = (r.cmd == CMD_DUAL_IO_READ) ? 4'h2 :
                  (r.cmd == CMD_QUAD_IO_READ) ? 4'h4 : 4'h1;
    end

    always_comb begin
        n = r;
        case (r.st)
            SFCR_CMD, SFCR_IDLE: begin
                n.sh = {r.sh[6:0], io_in[0]};
                n.cnt = r.cnt + 6'h1;
                if (r.cnt == 6'h7) begin
                    n.cmd = {r.sh[6:0], io_in[0]};
                    n.cnt = 6'h0;
                    n.st  = SFCR_DATA;
                    case ({r.sh[6:0], io_in[0]})
                        CMD_WRITE_REGISTERS: n.st = SFCR_WREG;
                        CMD_CLEAR_STATUS:    n.clr_tgl = ~r.clr_tgl; // R24
                        CMD_SOFT_RESET:      n.soft_tgl = ~r.soft_tgl;
                        CMD_WRITE_ENABLE:    n.wren_tgl = ~r.wren_tgl;
                        CMD_WRITE_DISABLE:   n.wrdi_tgl = ~r.wrdi_tgl;
                        CMD_READ, CMD_FAST_READ, CMD_DUAL_OUT_READ,
                        CMD_QUAD_OUT_READ, CMD_DUAL_IO_READ, CMD_QUAD_IO_READ:
                            n.st = SFCR_ADDR;
                        default: ;
                    endcase
                end
            end
            SFCR_ADDR: begin
                n.cnt = r.cnt + 6'(in_bits);
                if (r.cnt + 6'(in_bits) >= 6'(ADDR_BITS)) begin
                    n.cnt = 6'h0;
                    n.st  = (mode_cyc != 4'h0) ? SFCR_MODE :
                            (dummy_cyc != 4'h0) ? SFCR_DUMMY : SFCR_DATA; // R2
                end
            end
            SFCR_MODE: begin
                n.sh  = {r.sh[3:0], io_in};
                n.cnt = r.cnt + 6'h1;
                if (r.cnt + 6'h1 == 6'(mode_cyc)) begin
                    n.cnt  = 6'h0;
                    n.cont = ((r.cmd == CMD_QUAD_IO_READ) ? {r.sh[3:0], io_in} :
                              {r.sh[5:0], io_in[1:0]}) == CONT_MODE_BITS; // R8
                    n.st   = (dummy_cyc != 4'h0) ? SFCR_DUMMY : SFCR_DATA;
                end
            end
            SFCR_DUMMY: begin
                n.cnt = r.cnt + 6'h1;
                if (r.cnt + 6'h1 == 6'(dummy_cyc)) begin
                    n.cnt = 6'h0;
                    n.st  = SFCR_DATA;
                end
            end
            SFCR_WREG: begin
                n.sh  = {r.sh[6:0], io_in[0]};
                n.cnt = r.cnt + 6'h1;
                if (r.cnt == 6'h7) n.wr_stat = {r.sh[6:0], io_in[0]};
                if (r.cnt == 6'hF) begin
                    n.wr_cfg = {r.sh[6:0], io_in[0]}; // R1
                    n.wr_two = 1'b1;
                    n.wr_tgl = ~r.wr_tgl;
                    n.st = SFCR_DATA;
                end
            end
            default: begin
                n.cnt = r.cnt + 6'(width);
            end
        endcase
    end

    always_ff @(posedge sck_in or posedge cs_n_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r    <= '0;
            r.st <= SFCR_CMD;
        end else if (cs_n_in) begin
            r.cnt <= 6'h0;
            r.sh  <= 8'h00;
            if (r.cont) begin
                r.st <= SFCR_ADDR; // R8
            end else begin
                r.st  <= SFCR_CMD;
                r.cmd <= 8'h00;
            end
        end else begin
            r <= n;
        end
    end

    // output shifter on falling edge
    logic [7:0] out_sh;
    logic [3:0] out_q, out_oe;
    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            out_q  <= 4'h0;
            out_oe <= 4'h0;
            out_sh <= 8'h00;
        end else if (r.st == SFCR_DATA && (r.cmd == CMD_READ_CONFIG ||
                     r.cmd == CMD_READ_STATUS)) begin
            out_sh <= (r.cnt[2:0] == 3'h0) ?
                ((r.cmd == CMD_READ_CONFIG) ? cfg_s2 : stat_s2) : out_sh;
            out_q  <= {3'h0, (r.cnt[2:0] == 3'h0) ?
                ((r.cmd == CMD_READ_CONFIG) ? cfg_s2[7] : stat_s2[7]) : out_sh[6]};
            out_oe <= 4'h2;
            if (r.cnt[2:0] != 3'h0) out_sh <= {out_sh[6:0], 1'b0};
        end else if (r.st == SFCR_DATA) begin
            out_oe <= (width == 3'h4) ? 4'hF : (width == 3'h2) ? 4'h3 : 4'h2; // R15
            out_q  <= 4'h0;
        end else begin
            out_oe <= 4'h0;
        end
    end
    assign io_out    = (out_oe == 4'h2) ? {2'h0, out_q[0], 1'b0} : out_q;
    assign io_oe_out = out_oe;
    assign cfg_if.wr_tgl   = r.wr_tgl;
    assign cfg_if.wr_stat  = r.wr_stat;
    assign cfg_if.wr_cfg   = r.wr_cfg;
    assign cfg_if.wr_two   = r.wr_two;
    assign cfg_if.clr_tgl  = r.clr_tgl;
    assign cfg_if.soft_tgl = r.soft_tgl;
    assign cfg_if.wren_tgl = r.wren_tgl;
    assign cfg_if.wrdi_tgl = r.wrdi_tgl;
endmodule

// ### sfcr_pkg.sv
package sfcr_pkg;
    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_REGISTERS = 8'h01;
    localparam logic [7:0] CMD_READ_CONFIG     = 8'h35;
    localparam logic [7:0] CMD_READ_STATUS     = 8'h05;
    localparam logic [7:0] CMD_CLEAR_STATUS    = 8'h30;
    localparam logic [7:0] CMD_WRITE_ENABLE    = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE   = 8'h04;
    localparam logic [7:0] CMD_SOFT_RESET      = 8'hF0;
    localparam logic [7:0] CMD_READ            = 8'h03;
    localparam logic [7:0] CMD_FAST_READ       = 8'h0B;
    localparam logic [7:0] CMD_DUAL_OUT_READ   = 8'h3B;
    localparam logic [7:0] CMD_QUAD_OUT_READ   = 8'h6B;
    localparam logic [7:0] CMD_DUAL_IO_READ    = 8'hBB;
    localparam logic [7:0] CMD_QUAD_IO_READ    = 8'hEB;
    // ------------------------------------------------------------
    // config register fields
    // ------------------------------------------------------------
    localparam int LAT_HI_POS  = 7;
    localparam int LAT_LO_POS  = 6;
    localparam int TOP_BOTTOM_PROTECT_POS  = 5;
    localparam int RSVD_POS    = 4;
    localparam int PROTECT_VOLATILITY_SELECT_POS    = 3;
    localparam int PARM_POS    = 2;
    localparam int QUAD_POS    = 1;
    localparam int FREEZE_POS  = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] OTP_MASK  = 8'h2C;
    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int SWD_POS  = 7;
    localparam int PERR_POS = 6;
    localparam int BP_LSB   = 2;
    localparam int WEL_POS  = 1;
    localparam int BUSY_POS = 0;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [2:0] BP_VOLATILE_RESET = 3'h7;
    localparam int ADDR_BITS = 24;
    localparam logic [1:0] LC_NO_WAIT = 2'h3;
    localparam logic [1:0] LC_MID     = 2'h1;
    localparam logic [1:0] LC_HIGH    = 2'h2;
    localparam logic [3:0] DUMMY_EIGHT = 4'h8;
    localparam logic [3:0] MODE_DUAL_IO = 4'h4;
    localparam logic [3:0] MODE_QUAD_IO = 4'h2;
    localparam logic [7:0] CONT_MODE_BITS = 8'hA0;
    localparam logic [5:0] WRITE_BITS = 6'h10;
    // ------------------------------------------------------------
    // link state
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        SFCR_CMD   = 7'h01,
        SFCR_ADDR  = 7'h02,
        SFCR_MODE  = 7'h04,
        SFCR_DUMMY = 7'h08,
        SFCR_DATA  = 7'h10,
        SFCR_WREG  = 7'h20,
        SFCR_IDLE  = 7'h40
    } sfcr_state_t;
endpackage

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sfcr_pkg::*;
    logic       sys_clk_in = 0;
    logic       reset_n_in = 0;
    logic       uniform_sectors_in = 0;
    logic       wp_lvl = 1;
    logic       hold_lvl = 1;
    logic       sck, cs_n, si, from_bot, at_top, locked, wp_n, hold_n;
    logic [3:0] io_in, io_out, io_oe;
    logic [7:0] cfg, stat, rd;
    int         fail_count = 0;
    int         total_checks = 0;
    int         lat;
    always #25 sys_clk_in = ~sys_clk_in;
    assign io_in = {io_oe[3] ? io_out[3] : hold_lvl, io_oe[2] ? io_out[2] : wp_lvl,
                    io_oe[1] ? io_out[1] : ~si, io_oe[0] ? io_out[0] : si};
    sfcr_core DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .sck_in(sck),
        .cs_n_in(cs_n), .io_in(io_in), .uniform_sectors_in(uniform_sectors_in),
        .io_out(io_out), .io_oe_out(io_oe), .config_reg_one_out(cfg),
        .status_reg_one_out(stat), .protect_from_bottom_out(from_bot),
        .params_at_top_out(at_top), .otp_locked_out(locked), .wp_active_n_out(wp_n),
        .hold_active_n_out(hold_n));
    sfcr_host u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(io_in[1]),
        .so_oe_in(io_oe[1]));
    // ----
    // tasks
    // ----
    task automatic check8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic checkn(input string nm, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            fail_count++;
            $display("FAIL %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic wait_sys(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic send(input logic [7:0] c);
        u_host.frame(c, 32'h0, 0, 0, 0, rd, lat);
        wait_sys(40);
    endtask
    task automatic wreg(input logic [7:0] st, input logic [7:0] cf);
        send(CMD_WRITE_ENABLE);
        u_host.frame(CMD_WRITE_REGISTERS, {st, cf, 16'h0}, 16, 0, 0, rd, lat);
        wait_sys(40);
    endtask
    task automatic rdcfg(input logic [7:0] exp);
        u_host.frame(CMD_READ_CONFIG, 32'h0, 0, 8, 0, rd, lat);
        check8("read_config", exp, rd);
        wait_sys(4);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #2_000_000 fail_count++;
        report_and_stop();
    end
    // ----
    // tests
    // ----
    initial begin
        wait_sys(10);
        reset_n_in <= 1;
        wait_sys(5);
        check8("cfg_reset", CFG_RESET, cfg);
        check8("stat_reset", STAT_RESET, stat);
        rdcfg(8'h00);
        wreg(8'h80, 8'h00);
        @(posedge sys_clk_in) wp_lvl <= 0;
        wreg(8'h80, 8'hC0);
        check8("cfg_swd_lock", 8'h00, cfg);
        @(posedge sys_clk_in) wp_lvl <= 1;
        wreg(8'h00, 8'hC0);
        check8("cfg_open", 8'hC0, cfg);
        $display("test write lock done");
        wreg(8'h00, 8'hA6);
        rdcfg(8'hA6);
        check8("prot_bottom", 8'h01, {7'h0, from_bot});
        check8("parm_top", 8'h01, {7'h0, at_top});
        @(posedge sys_clk_in) uniform_sectors_in <= 1;
        wait_sys(6);
        check8("parm_uniform", 8'h00, {7'h0, at_top});
        uniform_sectors_in <= 0;
        wp_lvl <= 0;
        hold_lvl <= 0;
        wait_sys(6);
        check8("pins_inactive", 8'h03, {6'h0, wp_n, hold_n});
        wp_lvl <= 1;
        hold_lvl <= 1;
        wreg(8'h00, 8'h86);
        check8("otp_kept", 8'hA6, cfg);
        check8("perr_busy", 8'h41, stat & 8'h41);
        send(CMD_CLEAR_STATUS);
        check8("perr_clear", 8'h00, stat & 8'h41);
        $display("test otp done");
        wreg(8'h00, 8'h27);
        check8("freeze_set", 8'h27, cfg);
        check8("otp_locked", 8'h01, {7'h0, locked});
        wreg(8'h14, 8'hC3);
        check8("frozen_cfg", 8'hE7, cfg);
        check8("frozen_bp", 8'h00, stat & 8'h1C);
        send(CMD_CLEAR_STATUS);
        send(CMD_SOFT_RESET);
        check8("freeze_soft", 8'h01, cfg & 8'h01);
        @(posedge sys_clk_in) reset_n_in <= 0;
        wait_sys(10);
        reset_n_in <= 1;
        wait_sys(5);
        check8("freeze_hw", 8'h00, cfg & 8'h01);
        $display("test freeze done");
        for (int k = 0; k < 4; k++) begin
            wreg(8'h00, {k[1:0], 6'h02});
            u_host.frame(CMD_FAST_READ, 32'h0001_0000, 24, 8, 1, rd, lat);
            checkn("fast_read_dummy", (k == 3) ? 0 : 8, lat);
            u_host.frame(CMD_QUAD_OUT_READ, 32'h0001_0000, 24, 8, 1, rd, lat);
            checkn("quad_out_dummy", (k == 3) ? 0 : 8, lat);
            wait_sys(4);
        end
        $display("test latency done");
        report_and_stop();
    end
endmodule
